//--- fracn_pkg.sv
package fracn_pkg;

    // ------------------------------------------------------------
    // serial word layout
    // ------------------------------------------------------------
    localparam int SHIFT_W = 24;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_INT_FRACTION_WORD = 3'h0;
    localparam logic [2:0] CTRL_MOD_R = 3'h1;
    localparam int FRACTION_WORD_LSB = 3;
    localparam int INT_LSB = 15;
    localparam int MOD_LSB = 3;
    localparam int RDIV_LSB = 15;
    localparam int DBL_BIT = 19;
    localparam int TOG_BIT = 20;
    localparam int P8_BIT = 21;

    // ------------------------------------------------------------
    // widths, limits and reset values
    // ------------------------------------------------------------
    localparam int INT_W = 8;
    localparam int FRACTION_WORD_W = 12;
    localparam int RDIV_W = 4;
    localparam int NDIV_W = 9;
    localparam logic [7:0] INT_MIN = 8'h1a;
    localparam logic [11:0] MOD_MIN = 12'h002;
    localparam logic [3:0] PRE_LO = 4'h4;
    localparam logic [3:0] PRE_HI = 4'h8;

    // synchroniser lanes
    localparam int SY_REF = 0;
    localparam int SY_RF = 1;
    localparam int SY_LS = 2;
    localparam int SY_SCK = 3;
    localparam int SY_SDI = 4;
    localparam int SY_N = 5;

    // divider configuration carried as one unit
    typedef struct packed {
        logic [7:0] int_w;
        logic [11:0] fraction_word_w;
        logic [11:0] mod_w;
        logic [3:0] r_div;
        logic dbl;
        logic tog;
        logic p8;
    } cfg_t;

    localparam cfg_t CFG_RST = '{int_w: 8'h1a, fraction_word_w: 12'h000,
                                 mod_w: 12'h002, r_div: 4'h1,
                                 dbl: 1'b0, tog: 1'b0, p8: 1'b0};

endpackage

//--- sd_mash3.sv
`timescale 1ns/1ps
module sd_mash3 (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic step, // one pulse per detector period
    input wire logic [11:0] fraction_word_w, // fraction word
    input wire logic [11:0] mod_w, // modulus word
    output logic signed [3:0] y // division offset, -3..+4
);
    import fracn_pkg::*;

    typedef struct packed {
        logic [11:0] a1;
        logic [11:0] a2;
        logic [11:0] a3;
        logic c2d;
        logic c3d;
        logic c3dd;
        logic [3:0] y;
    } sd_t;

    sd_t r;
    sd_t n;

    // ------------------------------------------------------------
    // three cascaded first-order stages, noise shaped carries
    // ------------------------------------------------------------
    always_comb begin
        logic [12:0] s1;
        logic [12:0] s2;
        logic [12:0] s3;
        logic c1;
        logic c2;
        logic c3;
        s1 = '0;
        s2 = '0;
        s3 = '0;
        c1 = 1'b0;
        c2 = 1'b0;
        c3 = 1'b0;
        n = r;
        if (step) begin
            s1 = {1'b0, r.a1} + {1'b0, fraction_word_w};
            c1 = (s1 >= {1'b0, mod_w});
            n.a1 = c1 ? 12'(s1 - {1'b0, mod_w}) : s1[11:0];
            s2 = {1'b0, r.a2} + {1'b0, n.a1};
            c2 = (s2 >= {1'b0, mod_w});
            n.a2 = c2 ? 12'(s2 - {1'b0, mod_w}) : s2[11:0];
            s3 = {1'b0, r.a3} + {1'b0, n.a2};
            c3 = (s3 >= {1'b0, mod_w});
            n.a3 = c3 ? 12'(s3 - {1'b0, mod_w}) : s3[11:0];
            // average offset is fraction_word/mod, higher stages sum to zero
            n.y = 4'(c1) + 4'(c2) - 4'(r.c2d) + 4'(c3)
                - 4'({r.c3d, 1'b0}) + 4'(r.c3dd); // R13
            n.c2d = c2;
            n.c3d = c3;
            n.c3dd = r.c3d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign y = r.y;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_SD_RANGE: assert property (y >= -4'sd3 && y <= 4'sd4) // R13
        else $error("sigma-delta offset out of range");
    AST_SD_HOLD: assert property (!step |=> $stable(r.a1)) // R13
        else $error("accumulator moved without a step");

endmodule // sd_mash3

//--- fracn_divider.sv
`timescale 1ns/1ps
// Functional notes
// [R1] falling reference edge drives detector reference
// [R2] power-down opens path switches, closes shunt
// [R3] 4-bit counter divides (doubled) reference
// [R4] optional toggle halves, giving equal duty
// [R5] timer tick on detector reference falling edge
// [R6] programmer enables toggle above 120 MHz
// [R7] toggle advised for even divides above 2
// [R8] optional doubler counts both reference edges
// [R9] overall reference ratio from 0.5 to 30
// [R10] prescaler selectable 4/5 or 8/9
// [R11] programmer picks 8/9 above divide 80
// [R12] integer divide accepted 26 through 255
// [R13] third-order modulator interpolates fractional divide
// [R14] integer and fraction in separate registers; here one control word loads both
// [R15] output equals reference times int+fraction_word/mod
// [R16] programmer sets modulus before int, fraction_word
// [R17] 24-bit msb-first shift, load on strobe
// [R18] fraction_word below mod; values taken per period
module fracn_divider (
    input wire logic clk_sys, // system clock, 10 MHz
    input wire logic rst_n, // sync reset, active low
    input wire logic reference_clock_input, // reference pin
    input wire logic rf_feedback_input, // vco feedback pin
    input wire logic serial_clk, // serial clock pin
    input wire logic serial_data, // serial data pin
    input wire logic load_strobe, // serial load pin
    input wire logic power_down, // power-down control
    output logic detector_reference_clk, // detector reference
    output logic feedback_clk, // feedback divider pulse
    output logic timer_tick, // fast-lock timer clock pulse
    output logic ref_path_switch_a, // series switch, high closed
    output logic ref_path_switch_b, // series switch, high closed
    output logic ref_shunt_switch, // shunt switch, high closed
    output fracn_pkg::cfg_t cfg_active // configuration in use
);
    import fracn_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [23:0] shift;
        cfg_t cfg_sh;
        cfg_t cfg_a;
        logic [3:0] r_cnt;
        logic det_ref;
        logic det_d;
        logic tick;
        logic [8:0] n_cur;
        logic p8_cur;
        logic [3:0] pre_cnt;
        logic [2:0] swallow;
        logic [6:0] b_cnt;
        logic fb;
        logic sw_a;
        logic sw_b;
        logic sw_sh;
    } st_t;

    st_t r;
    st_t n;
    logic signed [3:0] sd_y;
    logic ref_rise;
    logic ref_fall;
    logic ref_evt;
    logic [3:0] r_eff;
    logic term;
    logic det_rise;
    logic det_nxt;
    logic rf_rise;
    logic ls_rise;
    logic sck_rise;
    logic [3:0] pre_mod;
    logic [2:0] a_val;
    logic [6:0] b_val;
    logic pre_wrap;
    logic [8:0] n_next;
    logic [11:0] fraction_word_in;
    logic [7:0] int_in;
    logic [11:0] mod_in;

    // ------------------------------------------------------------
    // edge events seen past the synchronisers
    // ------------------------------------------------------------
    // only second and third stages are read, so no metastable taps
    assign ref_rise = r.s2[SY_REF] & ~r.s3[SY_REF];
    assign ref_fall = ~r.s2[SY_REF] & r.s3[SY_REF];
    assign rf_rise = r.s2[SY_RF] & ~r.s3[SY_RF];
    assign ls_rise = r.s2[SY_LS] & ~r.s3[SY_LS];
    assign sck_rise = r.s2[SY_SCK] & ~r.s3[SY_SCK];

    // doubler takes both edges; otherwise only the falling one
    // counts, and nothing counts while the input is isolated
    assign ref_evt = !power_down
        && (r.cfg_a.dbl ? (ref_rise | ref_fall) // R8
                        : ref_fall); // R1 R2

    // a zero divide would stall the path, so it behaves as one
    assign r_eff = (r.cfg_a.r_div == 4'h0) ? 4'h1 : r.cfg_a.r_div; // R9
    assign term = ref_evt && (r.r_cnt == 4'(r_eff - 4'h1)); // R3
    // next detector level kept outside the state process, so that the
    // period boundary it marks does not loop back through that process
    assign det_nxt = r.cfg_a.tog ? (term ^ r.det_ref) : term; // R4
    assign det_rise = !r.det_ref && det_nxt;

    // ------------------------------------------------------------
    // prescaler split of the current divide value
    // ------------------------------------------------------------
    // n = p*b + a; p+1 for the first a prescaler cycles
    assign a_val = r.p8_cur ? r.n_cur[2:0] : {1'b0, r.n_cur[1:0]}; // R10
    assign b_val = r.p8_cur ? {1'b0, r.n_cur[8:3]} : r.n_cur[8:2];
    assign pre_mod = (r.p8_cur ? PRE_HI : PRE_LO)
                   + {3'h0, (r.swallow < a_val)};
    assign pre_wrap = rf_rise && (r.pre_cnt == 4'(pre_mod - 4'h1));
    // integer plus modulator offset, averaging int + fraction_word/mod
    assign n_next = {1'b0, r.cfg_a.int_w} + 9'(sd_y); // R15

    // serial fields of the word held in the shift register
    assign int_in = r.shift[INT_LSB +: INT_W];
    assign fraction_word_in = r.shift[FRACTION_WORD_LSB +: FRACTION_WORD_W];
    assign mod_in = r.shift[MOD_LSB +: FRACTION_WORD_W];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        // two-flop synchronisers for every pin
        n.s1 = {serial_data, serial_clk, load_strobe,
                rf_feedback_input, reference_clock_input};
        n.s2 = r.s1;
        n.s3 = r.s2;

        // serial word, most significant bit first
        if (sck_rise) begin
            n.shift = {r.shift[22:0], r.s2[SY_SDI]}; // R17
        end

        // transfer to the register picked by the low bits
        if (ls_rise) begin
            case (r.shift[CTRL_W-1:0])
                CTRL_INT_FRACTION_WORD: begin
                    // out-of-range integer words are dropped
                    if (int_in >= INT_MIN) begin
                        n.cfg_sh.int_w = int_in; // R12 R14
                    end
                    n.cfg_sh.fraction_word_w = fraction_word_in; // R14 R17
                end
                CTRL_MOD_R: begin
                    if (mod_in >= MOD_MIN) begin
                        n.cfg_sh.mod_w = mod_in; // R17
                    end
                    n.cfg_sh.r_div = r.shift[RDIV_LSB +: RDIV_W];
                    n.cfg_sh.dbl = r.shift[DBL_BIT];
                    n.cfg_sh.tog = r.shift[TOG_BIT];
                    n.cfg_sh.p8 = r.shift[P8_BIT];
                end
                default: begin
                    n.cfg_sh = r.cfg_sh;
                end
            endcase
        end

        // reference counter and optional toggle stage
        if (ref_evt) begin
            n.r_cnt = term ? 4'h0 : 4'(r.r_cnt + 4'h1); // R3
        end
        // toggle stage, when on, halves the count for equal duty
        n.det_ref = det_nxt; // R4
        // timer clocked from the falling edge, detector uses rising;
        // the tick follows the cycle in which the low level is first seen
        n.det_d = r.det_ref;
        n.tick = r.det_d && !r.det_ref; // R5

        // new words take effect only at a detector period boundary,
        // so the modulator never sees a half-updated set
        if (det_rise) begin
            n.cfg_a = r.cfg_sh; // R18
            if (r.cfg_sh.fraction_word_w >= r.cfg_sh.mod_w) begin
                n.cfg_a.fraction_word_w = 12'(r.cfg_sh.mod_w - 12'h001); // R18
            end
        end

        // dual-modulus prescaler and integer divider
        n.fb = 1'b0;
        if (rf_rise) begin
            n.pre_cnt = pre_wrap ? 4'h0 : 4'(r.pre_cnt + 4'h1); // R10
        end
        if (pre_wrap) begin
            if (r.swallow < a_val) begin
                n.swallow = 3'(r.swallow + 3'h1);
            end
            if (r.b_cnt == 7'(b_val - 7'h01)) begin
                // cycle done: reload with the modulated divide
                n.fb = 1'b1;
                n.b_cnt = 7'h00;
                n.swallow = 3'h0;
                n.n_cur = n_next; // R13 R15
                n.p8_cur = r.cfg_a.p8;
            end else begin
                n.b_cnt = 7'(r.b_cnt + 7'h01);
            end
        end

        // input isolation in power-down
        n.sw_a = !power_down; // R2
        n.sw_b = !power_down;
        n.sw_sh = power_down;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r <= '0;
            r.cfg_sh <= CFG_RST;
            r.cfg_a <= CFG_RST;
            r.n_cur <= {1'b0, INT_MIN};
            r.sw_a <= 1'b1;
            r.sw_b <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // fractional interpolator
    // ------------------------------------------------------------
    // steps once per detector period on the active edge
    sd_mash3 u_sd (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .step(det_rise),
        .fraction_word_w(r.cfg_a.fraction_word_w),
        .mod_w(r.cfg_a.mod_w),
        .y(sd_y)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign detector_reference_clk = r.det_ref;
    assign feedback_clk = r.fb;
    assign timer_tick = r.tick;
    assign ref_path_switch_a = r.sw_a;
    assign ref_path_switch_b = r.sw_b;
    assign ref_shunt_switch = r.sw_sh;
    assign cfg_active = r.cfg_a;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence det_fall_s;
        r.det_ref ##1 !r.det_ref;
    endsequence

    sequence load_mod_s;
        ls_rise && r.shift[CTRL_W-1:0] == CTRL_MOD_R
            && mod_in >= MOD_MIN;
    endsequence

    sequence load_int_s;
        ls_rise && r.shift[CTRL_W-1:0] == CTRL_INT_FRACTION_WORD
            && int_in >= INT_MIN;
    endsequence

    AST_FALL_EDGE: assert property ( // R1
        ref_evt && !r.cfg_a.dbl |-> r.s3[SY_REF] && !r.s2[SY_REF])
        else $error("reference counted on a rising edge");

    AST_PD_ISOLATE: assert property ( // R2
        power_down |=> !ref_path_switch_a && !ref_path_switch_b
            && ref_shunt_switch)
        else $error("reference not isolated in power-down");

    AST_PD_NO_EVT: assert property (power_down |-> !ref_evt) // R2
        else $error("reference edge counted in power-down");

    AST_RCOUNT: assert property (r.r_cnt < r_eff) // R3
        else $error("reference counter beyond its divide");

    AST_TOGGLE: assert property ( // R4
        r.cfg_a.tog && term && !det_rise |=> $changed(r.det_ref))
        else $error("toggle stage missed a terminal count");

    AST_TICK: assert property (det_fall_s |=> timer_tick ##1 !timer_tick)
        else $error("timer tick not on detector falling edge"); // R5

    AST_DOUBLER: assert property ( // R8
        r.cfg_a.dbl && !power_down && (ref_rise || ref_fall) |-> ref_evt)
        else $error("doubler dropped a reference edge");

    AST_RATIO: assert property (r_eff >= 4'h1 && r_eff <= 4'hf) // R9
        else $error("reference divide outside 1 to 15");

    AST_PRESC: assert property ( // R10
        r.pre_cnt <= (r.p8_cur ? PRE_HI : PRE_LO))
        else $error("prescaler count beyond its modulus");

    AST_INT_RANGE: assert property (r.cfg_a.int_w >= INT_MIN) // R12
        else $error("integer divide below minimum");

    AST_INT_LOAD: assert property ( // R14
        load_int_s |=> r.cfg_sh.int_w == $past(int_in))
        else $error("integer word not taken on load");

    AST_MOD_LOAD: assert property ( // R17
        load_mod_s |=> r.cfg_sh.mod_w == $past(mod_in))
        else $error("modulus word not taken on load");

    AST_FRACTION_WORD_LT_MOD: assert property ( // R18
        r.cfg_a.fraction_word_w < r.cfg_a.mod_w)
        else $error("active fraction not below modulus");

    AST_CFG_BOUNDARY: assert property ( // R18
        !det_rise |=> $stable(r.cfg_a))
        else $error("configuration changed mid period");

endmodule // fracn_divider

//--- fracn_far_end.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// far side: reference oscillator and vco feedback
// ------------------------------------------------------------
module fracn_far_end #(
    parameter int REF_HALF_NS = 600, // about 833 khz reference
    parameter int RF_HALF_NS = 300 // slow vco stand-in, 3 clocks per level
) (
    output logic reference_clock_input, // oscillator output
    output logic rf_feedback_input // vco output returned
);
    // free running oscillator; far below 120 mhz, so the toggle stage stays optional
    initial begin
        reference_clock_input = 1'b1;
        #430;
        forever begin
            reference_clock_input = ~reference_clock_input;
            #(REF_HALF_NS);
        end
    end
    // vco stand-in runs free; its edges sit off the system clock edges on purpose
    initial begin
        rf_feedback_input = 1'b0;
        #420;
        forever begin
            rf_feedback_input = ~rf_feedback_input;
            #(RF_HALF_NS);
        end
    end
endmodule // fracn_far_end

//--- fractional_n_divider_path_bench.sv
`timescale 1ns/1ps
module fractional_n_divider_path_bench;
    import fracn_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic clk_sys, rst_n, serial_clk, serial_data, load_strobe, power_down;
    logic reference_clock_input, rf_feedback_input, detector_reference_clk, feedback_clk;
    logic timer_tick, ref_path_switch_a, ref_path_switch_b, ref_shunt_switch;
    logic rf_q = 1'b0;
    cfg_t cfg_active;
    cfg_t exp_c;
    int miscompares = 0;
    int samples_checked = 0;
    int rf_cnt = 0;
    int fb_gap = 0;
    int fb_n = 0;
    int per, hi, tk, seen, sum;
    logic rr;
    // r_div, doubler, toggle, period and high time in clocks; reference period is 12
    int tbl[7][5] = '{'{1, 0, 0, 12, 1}, '{3, 0, 0, 36, 1}, '{3, 0, 1, 72, 36},
        '{1, 1, 0, 6, 1}, '{15, 0, 1, 360, 180}, '{0, 0, 0, 12, 1}, '{4, 0, 1, 96, 48}};

    fracn_divider dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .reference_clock_input(reference_clock_input), .rf_feedback_input(rf_feedback_input),
        .serial_clk(serial_clk), .serial_data(serial_data), .load_strobe(load_strobe),
        .power_down(power_down), .detector_reference_clk(detector_reference_clk),
        .feedback_clk(feedback_clk), .timer_tick(timer_tick),
        .ref_path_switch_a(ref_path_switch_a), .ref_path_switch_b(ref_path_switch_b),
        .ref_shunt_switch(ref_shunt_switch), .cfg_active(cfg_active));
    fracn_far_end far_u (.reference_clock_input(reference_clock_input),
        .rf_feedback_input(rf_feedback_input));

    // 10 mhz system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // count vco edges between feedback pulses; sampled mid-cycle where the pulse is settled
    always @(negedge clk_sys) begin
        if (feedback_clk === 1'b1) begin
            fb_gap = rf_cnt;
            fb_n++;
            rf_cnt = (rf_feedback_input === 1'b1 && rf_q === 1'b0) ? 1 : 0;
        end else if (rf_feedback_input === 1'b1 && rf_q === 1'b0) begin
            rf_cnt++;
        end
        rf_q = rf_feedback_input;
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // each level held 4 clocks since the pins pass a 2-flop synchroniser
    task automatic ser_write(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_data = w[i];
            cyc(4);
            serial_clk = 1'b1;
            cyc(4);
            serial_clk = 1'b0;
        end
        load_strobe = 1'b1;
        cyc(4);
        load_strobe = 1'b0;
        cyc(4);
    endtask
    function automatic logic [23:0] w_mr(input logic [11:0] m, input logic [3:0] r,
                                         input logic d, input logic t, input logic p);
        return {2'h0, p, t, d, r, m, CTRL_MOD_R};
    endfunction
    function automatic logic [23:0] w_if(input logic [7:0] n, input logic [11:0] f);
        return {1'b0, n, f, CTRL_INT_FRACTION_WORD};
    endfunction
    task automatic count_det(input int n, input int lim, output int got);
        logic prev;
        prev = detector_reference_clk;
        got = 0;
        for (int g = 0; g < lim && got < n; g++) begin
            cyc(1);
            if (detector_reference_clk === 1'b1 && prev === 1'b0) got++;
            prev = detector_reference_clk;
        end
    endtask
    // one detector period: length, high time, tick placement, reference level at the rise
    task automatic measure(output int p, output int h, output int t, output logic r);
        logic prev;
        logic rise;
        int fall_at;
        count_det(1, 3000, seen);
        r = reference_clock_input;
        p = 0;
        h = 0;
        t = 0;
        fall_at = -5;
        prev = 1'b1;
        forever begin
            cyc(1);
            p++;
            rise = detector_reference_clk === 1'b1 && prev === 1'b0;
            if (detector_reference_clk === 1'b1) h++;
            if (prev === 1'b1 && detector_reference_clk === 1'b0) fall_at = p;
            if (timer_tick === 1'b1) t += (p == fall_at + 1) ? 1 : 100;
            prev = detector_reference_clk;
            if (rise || p > 3000) break;
        end
    endtask
    task automatic next_fb();
        int start;
        start = fb_n;
        for (int g = 0; g < 4000 && fb_n == start; g++) cyc(1);
        check("feedback pulse seen", 64'h1, 64'(fb_n != start));
    endtask
    // wait for the words to go active; the third gap after that is wholly under them
    task automatic fb_check(input int n_exp);
        count_det(1, 3000, seen);
        repeat (3) next_fb();
        check("feedback divide", 64'(n_exp), 64'(fb_gap));
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // hang guard, well above the roughly 18500 clocks the tests need
    initial begin
        repeat (95000) @(posedge clk_sys);
        miscompares++;
        final_report();
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        {serial_clk, serial_data, load_strobe, power_down, rst_n} = 5'h00;
        cyc(8);
        rst_n = 1'b1;
        cyc(2);
        check("reset switches", 64'h6, 64'({ref_path_switch_a, ref_path_switch_b, ref_shunt_switch}));
        check("reset config", 64'(CFG_RST), 64'(cfg_active));
        $display("test reset done");
        foreach (tbl[i]) begin
            ser_write(w_mr(12'h004, 4'(tbl[i][0]), 1'(tbl[i][1]), 1'(tbl[i][2]), 1'b0));
            count_det(2, 3000, seen);
            measure(per, hi, tk, rr);
            measure(per, hi, tk, rr);
            check("detector period", 64'(tbl[i][3]), 64'(per));
            check("detector high time", 64'(tbl[i][4]), 64'(hi));
            check("timer tick after fall", 64'h1, 64'(tk));
            if (tbl[i][1] == 0) check("reference at detector rise", 64'h0, 64'(rr));
        end
        $display("test reference path done");
        power_down = 1'b1;
        cyc(4);
        check("power-down switches", 64'h1, 64'({ref_path_switch_a, ref_path_switch_b, ref_shunt_switch}));
        count_det(1, 200, seen);
        check("detector rises in power-down", 64'h0, 64'(seen));
        power_down = 1'b0;
        cyc(4);
        check("restored switches", 64'h6, 64'({ref_path_switch_a, ref_path_switch_b, ref_shunt_switch}));
        $display("test power-down done");
        ser_write(w_mr(12'h004, 4'hf, 1'b0, 1'b0, 1'b0));
        ser_write(w_if(8'h1e, 12'h000));
        fb_check(30);
        ser_write(w_if(8'h1a, 12'h000));
        fb_check(26);
        ser_write(w_mr(12'h004, 4'hf, 1'b0, 1'b0, 1'b1));
        ser_write(w_if(8'hff, 12'h000));
        fb_check(255);
        ser_write(w_if(8'h19, 12'h000));
        count_det(2, 3000, seen);
        check("integer below range kept", 64'hff, 64'(cfg_active.int_w));
        ser_write(w_mr(12'h004, 4'hf, 1'b0, 1'b0, 1'b0));
        ser_write(w_if(8'h1e, 12'h007));
        count_det(2, 3000, seen);
        exp_c = '{int_w: 8'h1e, fraction_word_w: 12'h003, mod_w: 12'h004, r_div: 4'hf,
                  dbl: 1'b0, tog: 1'b0, p8: 1'b0};
        check("fraction clamped config", 64'(exp_c), 64'(cfg_active));
        repeat (3) next_fb();
        sum = 0;
        for (int k = 0; k < 32; k++) begin
            next_fb();
            sum += fb_gap;
        end
        // 32 gaps of 30 + 3/4 average 984; sampling slip between the two rates allowed
        check("fractional average", 64'h1, 64'(sum >= 976 && sum <= 992));
        ser_write({21'h1fffff, 3'h3});
        count_det(2, 3000, seen);
        check("other control code ignored", 64'(exp_c), 64'(cfg_active));
        $display("test feedback path done");
        final_report();
    end
endmodule // fractional_n_divider_path_bench
